//--- bench/nscr_props.sv
// assertion checker for the node switch configuration register bank
`timescale 1ns/1ps

module nscr_props (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire logic route_req_i,
    input wire logic [15:0] route_dest_i,
    input wire logic route_valid_o,
    input wire logic route_local_o,
    input wire logic [3:0] route_dir_o,
    input wire logic [15:0] node_id_o,
    input wire logic [6:0] pll_in_div_o,
    input wire logic pll_update_o,
    input wire logic tile_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // --------
    // steps
    // --------
    sequence s_read(a);
        cfg_rd_i && cfg_addr_i == a ##1 cfg_rvalid_o;
    endsequence
    sequence s_pll_take;
        cfg_wr_i && cfg_addr_i == nscr_pkg::REG_PLL_SETUP ##1 pll_update_o;
    endsequence

    // --------
    // checks
    // --------
    chk_read_answer: assert property (
        !$past(sys_rst_i) |-> cfg_rvalid_o == $past(cfg_rd_i)) else $error("read answer late or missing");
    chk_rdata_idle: assert property (
        !cfg_rvalid_o |-> cfg_rdata_o == 32'h0) else $error("read data not zero when idle");
    chk_res_read: assert property (
        s_read(nscr_pkg::REG_SWITCH_RESOURCES) |-> cfg_rdata_o == {8'h00, nscr_pkg::NUM_SWITCH_LINKS,
        nscr_pkg::NUM_SWITCH_PROCS, nscr_pkg::NUM_DEVICE_PROCS}) else $error("resources read wrong");
    chk_pll_field: assert property (
        s_pll_take |-> pll_in_div_o == $past(cfg_wdata_i[6:0])) else $error("pll input divider not taken");
    chk_tile_reset: assert property (
        s_pll_take |-> tile_reset_o == !$past(cfg_wdata_i[31])) else $error("tile reset pulse wrong");
    chk_pll_cause: assert property (
        pll_update_o || tile_reset_o |-> pll_update_o && $past(cfg_wr_i && cfg_addr_i == 8'h06))
        else $error("pll pulse without pll write");
    chk_node_hold: assert property (
        !$past(sys_rst_i) && $changed(node_id_o) |-> $past(cfg_wr_i && cfg_addr_i == 8'h05)
        && node_id_o == $past(cfg_wdata_i[15:0])) else $error("node id changed without write");
    chk_route_answer: assert property (
        !$past(sys_rst_i) |-> route_valid_o == $past(route_req_i)) else $error("route answer late or missing");
    chk_route_local: assert property (
        route_valid_o |-> route_local_o == ($past(route_dest_i) == $past(node_id_o))
        && (!route_local_o || route_dir_o == 4'h0)) else $error("local delivery wrong");
endmodule

bind nscr_node_switch_config_regs nscr_props i_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .route_req_i(route_req_i),
    .route_dest_i(route_dest_i), .route_valid_o(route_valid_o), .route_local_o(route_local_o),
    .route_dir_o(route_dir_o), .node_id_o(node_id_o), .pll_in_div_o(pll_in_div_o),
    .pll_update_o(pll_update_o), .tile_reset_o(tile_reset_o));

//--- bench/tb.sv
// self-checking testbench for the node switch configuration register bank
`timescale 1ns/1ps

module tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] boot_control_pins_i = 8'h00;
    logic cfg_wr_i = 1'b0;
    logic cfg_rd_i = 1'b0;
    logic [7:0] cfg_addr_i = 8'h00;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic route_req_i = 1'b0;
    logic [15:0] route_dest_i = 16'h0;
    logic [31:0] cfg_rdata_o;
    logic cfg_rvalid_o, route_valid_o, route_local_o, header_one_byte_o;
    logic pll_no_relock_wait_o, pll_bypass_o, boot_from_jtag_o, pll_update_o, tile_reset_o;
    logic [3:0] route_dir_o;
    logic [15:0] node_id_o, switch_clk_div_o, ref_clk_div_o;
    logic [2:0] pll_out_div_o;
    logic [12:0] pll_fb_mul_o;
    logic [6:0] pll_in_div_o;
    logic [31:0] shadow [0:15];
    int err_count = 0;
    int total_checks = 0;

    always #4 clk_i = ~clk_i;

    nscr_node_switch_config_regs i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .boot_control_pins_i(boot_control_pins_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_rvalid_o(cfg_rvalid_o), .route_req_i(route_req_i), .route_dest_i(route_dest_i),
        .route_valid_o(route_valid_o), .route_local_o(route_local_o), .route_dir_o(route_dir_o),
        .header_one_byte_o(header_one_byte_o), .node_id_o(node_id_o),
        .pll_no_relock_wait_o(pll_no_relock_wait_o), .pll_bypass_o(pll_bypass_o),
        .boot_from_jtag_o(boot_from_jtag_o), .pll_out_div_o(pll_out_div_o), .pll_fb_mul_o(pll_fb_mul_o),
        .pll_in_div_o(pll_in_div_o), .pll_update_o(pll_update_o), .tile_reset_o(tile_reset_o),
        .switch_clk_div_o(switch_clk_div_o), .ref_clk_div_o(ref_clk_div_o));

    // --------
    // expectations
    // --------
    function automatic logic [31:0] wmask(input logic [7:0] a);
        if (shadow[4][31]) return 32'h0;
        case (a)
            8'h04: return 32'h8000_0101;
            8'h05, 8'h07, 8'h08: return 32'h0000_ffff;
            8'h06: return shadow[4][8] ? 32'h0 : 32'hf39f_ff7f;
            8'h0c, 8'h0d: return 32'hffff_ffff;
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic [31:0] exp_read(input logic [7:0] a);
        case (a)
            8'h00: return {8'h00, boot_control_pins_i, nscr_pkg::SWITCH_REVISION, nscr_pkg::SWITCH_VERSION};
            8'h01: return {8'h00, nscr_pkg::NUM_SWITCH_LINKS, nscr_pkg::NUM_SWITCH_PROCS, nscr_pkg::NUM_DEVICE_PROCS};
            8'h09: return {nscr_pkg::JTAG_VERSION, nscr_pkg::JTAG_PART, nscr_pkg::JTAG_MAKER, 1'b1};
            8'h0a: return {nscr_pkg::OTP_USER_CODE, nscr_pkg::METAL_ID_CODE};
            default: return (a < 8'h10) ? shadow[a[3:0]] : 32'h0;
        endcase
    endfunction

    function automatic logic [3:0] exp_dir(input logic [15:0] dest);
        logic [15:0] diff;
        logic [3:0] dir;
        diff = dest ^ shadow[5][15:0];
        dir = 4'h0;
        for (int d = 0; d < 16; d++) begin
            if (diff[d]) dir = (d < 8) ? shadow[12][4*d +: 4] : shadow[13][4*(d-8) +: 4];
        end
        return dir;
    endfunction

    // --------
    // bus tasks
    // --------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] m;
        m = wmask(a);
        @(posedge clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_wdata_i <= d;
        @(posedge clk_i);
        cfg_wr_i <= 1'b0;
        cfg_wdata_i <= ~d;
        if (a < 8'h10) shadow[a[3:0]] = (shadow[a[3:0]] & ~m) | (d & m);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge clk_i);
        cfg_rd_i <= 1'b0;
        #1;
        check("rvalid", {31'h0, cfg_rvalid_o}, 32'h1);
        check("rdata", cfg_rdata_o, exp_read(a));
    endtask

    task automatic check_outs();
        check("node_id", {16'h0, node_id_o}, shadow[5] & 32'h0000_ffff);
        check("header", {31'h0, header_one_byte_o}, {31'h0, shadow[4][0]});
        check("sw_div", {16'h0, switch_clk_div_o}, {16'h0, shadow[7][15:0]});
        check("ref_div", {16'h0, ref_clk_div_o}, {16'h0, shadow[8][15:0]});
        check("pll", {6'h0, pll_no_relock_wait_o, pll_bypass_o, boot_from_jtag_o, pll_out_div_o, pll_fb_mul_o,
            pll_in_div_o}, {6'h0, shadow[6][30:28], shadow[6][25:23], shadow[6][20:8], shadow[6][6:0]});
    endtask

    task automatic route(input logic [15:0] dest);
        @(posedge clk_i);
        route_req_i <= 1'b1;
        route_dest_i <= dest;
        @(posedge clk_i);
        route_req_i <= 1'b0;
        #1;
        check("route_valid", {31'h0, route_valid_o}, 32'h1);
        check("route_local", {31'h0, route_local_o}, {31'h0, dest == shadow[5][15:0]});
        check("route_dir", {28'h0, route_dir_o}, {28'h0, exp_dir(dest)});
    endtask

    task automatic do_reset();
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        foreach (shadow[i]) shadow[i] = 32'h0;
        shadow[8] = 32'h0000_0003;
        repeat (6) @(posedge clk_i);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // --------
    // tests
    // --------
    initial begin
        logic [31:0] v;
        void'($urandom(47));
        boot_control_pins_i = 8'($urandom);
        do_reset();
        for (int a = 0; a < 17; a++) rd(8'(a));
        check_outs();
        $display("test reset_values done");
        for (int n = 0; n < 3; n++) begin
            for (int a = 0; a < 17; a++) wr(a == 16 ? 8'h3f : 8'(a), (a == 4) ? $urandom & 32'h7fff_feff : $urandom);
            for (int a = 0; a < 17; a++) rd(a == 16 ? 8'h3f : 8'(a));
            check_outs();
        end
        $display("test random_access done");
        for (int b = 0; b < 4; b++) begin
            v = (b == 0) ? 32'hffff_ffff : (b == 1) ? 32'h0 : {b[0], 31'($urandom)};
            wr(8'h06, v);
            check("pll_update", {31'h0, pll_update_o}, 32'h1);
            check("tile_reset", {31'h0, tile_reset_o}, {31'h0, ~v[31]});
            check_outs();
        end
        $display("test pll_write done");
        for (int k = 0; k < 16; k++) route(shadow[5][15:0] ^ (16'h1 << k) ^ (16'($urandom) & ((16'h1 << k) - 16'h1)));
        route(shadow[5][15:0]);
        for (int k = 0; k < 20; k++) route(16'($urandom));
        $display("test routing done");
        wr(8'h04, 32'h0000_0101);
        wr(8'h06, ~shadow[6]);
        check("pll_locked", {31'h0, pll_update_o}, 32'h0);
        wr(8'h07, $urandom);
        check_outs();
        wr(8'h04, 32'h8000_0000);
        for (int a = 0; a < 16; a++) begin
            wr(8'(a), ~exp_read(8'(a)));
            check("lock_all", {31'h0, pll_update_o}, 32'h0);
            rd(8'(a));
        end
        check_outs();
        $display("test write_locks done");
        do_reset();
        rd(8'h00);
        rd(8'h04);
        check_outs();
        route(16'h0000);
        $display("test second_reset done");
        finish_test();
    end

    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        finish_test();
    end
endmodule

//--- logic/nscr_node_switch_config_regs.sv
// node switch configuration register bank with routing direction lookup
`timescale 1ns/1ps

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
// 0x00 device_identity, read only
//   31:24 reserved, reads zero
//   23:16 boot pins caught after reset
//   15:8 switch revision
//   7:0 switch version
// switch_resources switch_resources, read only
//   31:24 reserved
//   23:16 switch links
//   15:8 processors on the switch
//   7:0 processors on the device
// 0x04 switch_protection_header
//   31 lock all writes
//   30:9 reserved
//   8 lock pll register writes
//   7:1 reserved
//   0 one-byte headers when set
// 0x05 node_identity
//   31:16 reserved
//   15:0 node id
// 0x06 pll_setup
//   31 no tile reset on this write
//   30 no relock wait
//   29 pll bypass
//   28 boot from jtag
//   27:26 reserved
//   25:23 output divide minus one
//   22:21 reserved
//   20:8 feedback multiply minus one
//   7 reserved
//   6:0 input divide minus one
// switch_clock_divider switch_clock_divider
//   31:16 reserved
//   15:0 switch clock ratio
// 0x08 reference_clock_divider
//   31:16 reserved
//   15:0 reference clock ratio, resets to 3
// jtag_identity jtag_identity, read only
//   31:28 version
//   27:12 part
//   11:1 maker
//   0 always one
// user_code user_code, read only
//   31:18 one-time-programmed user code
//   17:0 metal fix id
// 0x0c route_dirs_low
//   nibble d steers mismatch bit d, d 0..7
// 0x0d route_dirs_high
//   nibble d steers mismatch bit d+8
// other numbers read zero, writes dropped
//
// lock all also locks its own register,
// so only reset reopens the bank

// ------------------------------------------------------------
// port timing
// ------------------------------------------------------------
// read: strobe at edge n, data and valid at n+1
// rdata is zero outside the valid cycle
// write: effect visible one cycle after the edge
// read and write together: read returns old value
// route: answer one cycle after the request
// route uses node id and tables as before
//   any write in the same cycle
// boot byte caught four edges after reset release;
//   reads before that show stale bits
// boot byte survives reset until caught again
// pll write: update pulses for one cycle,
//   tile reset too unless bit 31 is set
// pulses clear the cycle after
// one lookup per cycle, no queue

module nscr_node_switch_config_regs (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] boot_control_pins_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic route_req_i,
    input wire logic [15:0] route_dest_i,
    output logic route_valid_o,
    output logic route_local_o,
    output logic [3:0] route_dir_o,
    output logic header_one_byte_o,
    output logic [15:0] node_id_o,
    output logic pll_no_relock_wait_o,
    output logic pll_bypass_o,
    output logic boot_from_jtag_o,
    output logic [2:0] pll_out_div_o,
    output logic [12:0] pll_fb_mul_o,
    output logic [6:0] pll_in_div_o,
    output logic pll_update_o,
    output logic tile_reset_o,
    output logic [15:0] switch_clk_div_o,
    output logic [15:0] ref_clk_div_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] boot_sync1;
        logic [7:0] boot_sync2;
        nscr_pkg::nscr_cap_e cap;
        logic [1:0] cap_cnt;
        logic [7:0] boot_pins;
        logic [31:0] cfg;
        logic [15:0] node_id;
        logic [31:0] pll;
        logic [15:0] sw_div;
        logic [15:0] ref_div;
        logic [31:0] dirs_low;
        logic [31:0] dirs_high;
        logic [31:0] rdata;
        logic rvalid;
        logic pll_update;
        logic tile_reset;
        logic route_valid;
        logic route_local;
        logic [3:0] route_dir;
    } nscr_state_s;

    nscr_state_s st;
    nscr_state_s next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // keeps writable bits from new value, others from old
    function automatic logic [31:0] nscr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [31:0] mask);
        nscr_merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // index of the highest set bit; zero when none
    function automatic logic [3:0] nscr_top_bit(input logic [15:0] v);
        nscr_top_bit = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                nscr_top_bit = 4'(i);
            end
        end
    endfunction

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    function automatic logic [31:0] nscr_read(input nscr_state_s s, input logic [7:0] addr);
        nscr_read = 32'h0000_0000;
        case (addr)
            nscr_pkg::REG_DEVICE_IDENTITY: begin
                nscr_read = ({24'h00_0000, s.boot_pins} << nscr_pkg::ID_BOOT_LSB)
                    | ({24'h00_0000, nscr_pkg::SWITCH_REVISION} << nscr_pkg::ID_REV_LSB)
                    | ({24'h00_0000, nscr_pkg::SWITCH_VERSION} << nscr_pkg::ID_VER_LSB);
            end
            nscr_pkg::REG_SWITCH_RESOURCES: begin
                nscr_read = ({24'h00_0000, nscr_pkg::NUM_SWITCH_LINKS} << nscr_pkg::RES_LINKS_LSB)
                    | ({24'h00_0000, nscr_pkg::NUM_SWITCH_PROCS} << nscr_pkg::RES_SW_PROC_LSB)
                    | ({24'h00_0000, nscr_pkg::NUM_DEVICE_PROCS} << nscr_pkg::RES_DEV_PROC_LSB);
            end
            nscr_pkg::REG_SWITCH_PROTECTION_HEADER: begin
                nscr_read = s.cfg;
            end
            nscr_pkg::REG_NODE_IDENTITY: begin
                nscr_read = {16'h0000, s.node_id};
            end
            nscr_pkg::REG_PLL_SETUP: begin
                nscr_read = s.pll;
            end
            nscr_pkg::REG_SWITCH_CLOCK_DIVIDER: begin
                nscr_read = {16'h0000, s.sw_div};
            end
            nscr_pkg::REG_REFERENCE_CLOCK_DIVIDER: begin
                nscr_read = {16'h0000, s.ref_div};
            end
            nscr_pkg::REG_JTAG_IDENTITY: begin
                nscr_read = ({28'h000_0000, nscr_pkg::JTAG_VERSION} << nscr_pkg::JTAG_VER_LSB)
                    | ({16'h0000, nscr_pkg::JTAG_PART} << nscr_pkg::JTAG_PART_LSB)
                    | ({21'h00_0000, nscr_pkg::JTAG_MAKER} << nscr_pkg::JTAG_MAKER_LSB)
                    | 32'h0000_0001;
            end
            nscr_pkg::REG_USER_CODE: begin
                nscr_read = ({18'h0_0000, nscr_pkg::OTP_USER_CODE} << nscr_pkg::USER_OTP_LSB)
                    | ({14'h0000, nscr_pkg::METAL_ID_CODE} << nscr_pkg::USER_METAL_LSB);
            end
            nscr_pkg::REG_ROUTE_DIRS_LOW: begin
                nscr_read = s.dirs_low;
            end
            nscr_pkg::REG_ROUTE_DIRS_HIGH: begin
                nscr_read = s.dirs_high;
            end
            default: begin
                nscr_read = 32'h0000_0000;
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic wr_open;
    logic pll_open;
    logic [15:0] mismatch;
    logic [3:0] dim;
    logic [63:0] dir_table;

    always_comb begin
        next_st = st;
        wr_open = ~st.cfg[nscr_pkg::CFG_LOCK_ALL_BIT];
        pll_open = wr_open & ~st.cfg[nscr_pkg::CFG_LOCK_PLL_BIT];
        mismatch = route_dest_i ^ st.node_id;
        dim = nscr_top_bit(mismatch);
        dir_table = {st.dirs_high, st.dirs_low};

        // boot pins pass two flops, then are caught once
        next_st.boot_sync1 = boot_control_pins_i;
        next_st.boot_sync2 = st.boot_sync1;
        case (st.cap)
            nscr_pkg::NSCR_CAP_WAIT: begin
                next_st.cap_cnt = 2'h0;
                next_st.cap = nscr_pkg::NSCR_CAP_SETTLE;
            end
            nscr_pkg::NSCR_CAP_SETTLE: begin
                next_st.cap_cnt = st.cap_cnt + 2'h1;
                if (st.cap_cnt == nscr_pkg::BOOT_SYNC_CYCLES) begin
                    next_st.boot_pins = st.boot_sync2;
                    next_st.cap = nscr_pkg::NSCR_CAP_DONE;
                end
            end
            nscr_pkg::NSCR_CAP_DONE: begin
                next_st.cap = nscr_pkg::NSCR_CAP_DONE;
            end
            default: begin
                next_st.cap = nscr_pkg::NSCR_CAP_WAIT;
            end
        endcase

        // register reads by number
        next_st.rvalid = cfg_rd_i;
        next_st.rdata = cfg_rd_i ? nscr_read(st, cfg_addr_i) : 32'h0000_0000;

        // register writes; blocked or read-only bits are dropped
        next_st.pll_update = 1'b0;
        next_st.tile_reset = 1'b0;
        if (cfg_wr_i && wr_open) begin
            case (cfg_addr_i)
                nscr_pkg::REG_SWITCH_PROTECTION_HEADER: begin
                    next_st.cfg = nscr_merge(st.cfg, cfg_wdata_i,
                                             nscr_pkg::MASK_SWITCH_PROTECTION_HEADER);
                end
                nscr_pkg::REG_NODE_IDENTITY: begin
                    next_st.node_id = cfg_wdata_i[15:0];
                end
                nscr_pkg::REG_PLL_SETUP: begin
                    if (pll_open) begin
                        next_st.pll = nscr_merge(st.pll, cfg_wdata_i, nscr_pkg::MASK_PLL_SETUP);
                        next_st.pll_update = 1'b1;
                        next_st.tile_reset = ~cfg_wdata_i[nscr_pkg::PLL_NO_CHIP_RESET_BIT];
                    end
                end
                nscr_pkg::REG_SWITCH_CLOCK_DIVIDER: begin
                    next_st.sw_div = cfg_wdata_i[15:0];
                end
                nscr_pkg::REG_REFERENCE_CLOCK_DIVIDER: begin
                    next_st.ref_div = cfg_wdata_i[15:0];
                end
                nscr_pkg::REG_ROUTE_DIRS_LOW: begin
                    next_st.dirs_low = cfg_wdata_i;
                end
                nscr_pkg::REG_ROUTE_DIRS_HIGH: begin
                    next_st.dirs_high = cfg_wdata_i;
                end
                default: begin
                    next_st.cfg = st.cfg;
                end
            endcase
        end

        // direction lookup
        next_st.route_valid = route_req_i;
        next_st.route_local = route_req_i & (mismatch == 16'h0000);
        next_st.route_dir = 4'h0;
        if (route_req_i && mismatch != 16'h0000) begin
            next_st.route_dir = dir_table[{dim, 2'b00} +: 4];
        end

        if (sys_rst_i) begin
            next_st.cap = nscr_pkg::NSCR_CAP_WAIT;
            next_st.cap_cnt = 2'h0;
            next_st.cfg = nscr_pkg::RST_SWITCH_PROTECTION_HEADER;
            next_st.node_id = nscr_pkg::RST_NODE_IDENTITY;
            next_st.pll = nscr_pkg::RST_PLL_SETUP;
            next_st.sw_div = nscr_pkg::RST_SWITCH_CLOCK_DIVIDER;
            next_st.ref_div = nscr_pkg::RST_REFERENCE_CLOCK_DIVIDER;
            next_st.dirs_low = nscr_pkg::RST_ROUTE_DIRS;
            next_st.dirs_high = nscr_pkg::RST_ROUTE_DIRS;
            next_st.rdata = 32'h0000_0000;
            next_st.rvalid = 1'b0;
            next_st.pll_update = 1'b0;
            next_st.tile_reset = 1'b0;
            next_st.route_valid = 1'b0;
            next_st.route_local = 1'b0;
            next_st.route_dir = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cfg_rdata_o = st.rdata;
    assign cfg_rvalid_o = st.rvalid;
    assign route_valid_o = st.route_valid;
    assign route_local_o = st.route_local;
    assign route_dir_o = st.route_dir;
    assign header_one_byte_o = st.cfg[nscr_pkg::CFG_HDR_ONE_BYTE_BIT];
    assign node_id_o = st.node_id;
    assign pll_no_relock_wait_o = st.pll[nscr_pkg::PLL_NO_RELOCK_WAIT_BIT];
    assign pll_bypass_o = st.pll[nscr_pkg::PLL_BYPASS_BIT];
    assign boot_from_jtag_o = st.pll[nscr_pkg::PLL_BOOT_JTAG_BIT];
    assign pll_out_div_o = st.pll[nscr_pkg::PLL_OUT_DIV_LSB +: 3];
    assign pll_fb_mul_o = st.pll[nscr_pkg::PLL_FB_MUL_LSB +: 13];
    assign pll_in_div_o = st.pll[nscr_pkg::PLL_IN_DIV_LSB +: 7];
    assign pll_update_o = st.pll_update;
    assign tile_reset_o = st.tile_reset;
    assign switch_clk_div_o = st.sw_div;
    assign ref_clk_div_o = st.ref_div;

endmodule

//--- logic/nscr_pkg.sv
// constants and types for the node switch configuration register bank
package nscr_pkg;

    // ------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------
    localparam logic [7:0] REG_DEVICE_IDENTITY = 8'h00;
    localparam logic [7:0] REG_SWITCH_RESOURCES = 8'h01;
    localparam logic [7:0] REG_SWITCH_PROTECTION_HEADER = 8'h04;
    localparam logic [7:0] REG_NODE_IDENTITY = 8'h05;
    localparam logic [7:0] REG_PLL_SETUP = 8'h06;
    localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
    localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
    localparam logic [7:0] REG_JTAG_IDENTITY = 8'h09;
    localparam logic [7:0] REG_USER_CODE = 8'h0a;
    localparam logic [7:0] REG_ROUTE_DIRS_LOW = 8'h0c;
    localparam logic [7:0] REG_ROUTE_DIRS_HIGH = 8'h0d;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ID_BOOT_LSB = 16;
    localparam int ID_REV_LSB = 8;
    localparam int ID_VER_LSB = 0;
    localparam int RES_LINKS_LSB = 16;
    localparam int RES_SW_PROC_LSB = 8;
    localparam int RES_DEV_PROC_LSB = 0;
    localparam int CFG_LOCK_ALL_BIT = 31;
    localparam int CFG_LOCK_PLL_BIT = 8;
    localparam int CFG_HDR_ONE_BYTE_BIT = 0;
    localparam int PLL_NO_CHIP_RESET_BIT = 31;
    localparam int PLL_NO_RELOCK_WAIT_BIT = 30;
    localparam int PLL_BYPASS_BIT = 29;
    localparam int PLL_BOOT_JTAG_BIT = 28;
    localparam int PLL_OUT_DIV_LSB = 23;
    localparam int PLL_FB_MUL_LSB = 8;
    localparam int PLL_IN_DIV_LSB = 0;
    localparam int JTAG_VER_LSB = 28;
    localparam int JTAG_PART_LSB = 12;
    localparam int JTAG_MAKER_LSB = 1;
    localparam int USER_OTP_LSB = 18;
    localparam int USER_METAL_LSB = 0;

    // writable bits of each register
    localparam logic [31:0] MASK_SWITCH_PROTECTION_HEADER = 32'h8000_0101;
    localparam logic [31:0] MASK_NODE_IDENTITY = 32'h0000_ffff;
    localparam logic [31:0] MASK_PLL_SETUP = 32'hf39f_ff7f;
    localparam logic [31:0] MASK_DIVIDER = 32'h0000_ffff;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_SWITCH_PROTECTION_HEADER = 32'h0000_0000;
    localparam logic [15:0] RST_NODE_IDENTITY = 16'h0000;
    localparam logic [31:0] RST_PLL_SETUP = 32'h0000_0000;
    localparam logic [15:0] RST_SWITCH_CLOCK_DIVIDER = 16'h0000;
    localparam logic [15:0] RST_REFERENCE_CLOCK_DIVIDER = 16'h0003;
    localparam logic [31:0] RST_ROUTE_DIRS = 32'h0000_0000;

    // ------------------------------------------------------------
    // fixed identity and resources (values arbitrary)
    // ------------------------------------------------------------
    localparam logic [7:0] SWITCH_REVISION = 8'h01;
    localparam logic [7:0] SWITCH_VERSION = 8'h02;
    localparam logic [7:0] NUM_SWITCH_LINKS = 8'h08;
    localparam logic [7:0] NUM_SWITCH_PROCS = 8'h01;
    localparam logic [7:0] NUM_DEVICE_PROCS = 8'h02;
    localparam logic [3:0] JTAG_VERSION = 4'h1;
    localparam logic [15:0] JTAG_PART = 16'h1234;
    localparam logic [10:0] JTAG_MAKER = 11'h055;
    localparam logic [13:0] OTP_USER_CODE = 14'h0000;
    localparam logic [17:0] METAL_ID_CODE = 18'h00001;

    // cycles of boot pin synchroniser before capture
    localparam logic [1:0] BOOT_SYNC_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        NSCR_CAP_WAIT = 2'b00,
        NSCR_CAP_SETTLE = 2'b01,
        NSCR_CAP_DONE = 2'b11
    } nscr_cap_e;

endpackage
